// ==== verilog/ssb_step_sequencer_bank.sv ====
// ssb_step_sequencer_bank: eight step sequencers behind an apb slave
// assumes ladder commands come from logic on clk_sys, apb on clk_sys
`timescale 1ns/1ps
module ssb_step_sequencer_bank
  import ssb_pkg::*;
(
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [ADDR_W-1:0]               paddr,
  input  wire logic [DATA_W-1:0]               pwdata,
  output logic [DATA_W-1:0]                    prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // ladder commands
  input  wire ssb_cmd_t [SEQ_COUNT-1:0]        seqCmd,
  // sequencer state
  output logic [SEQ_COUNT-1:0][FLAG_N-1:0]     stepFlag,
  output logic [SEQ_COUNT-1:0]                 completeFlag,
  // interrupt
  output logic                                 irq
);
  logic                            setup;
  logic                            wrAcc;
  logic                            statusWr;
  logic                            maskWr;
  logic                            addrKnown;
  logic [DATA_W-1:0]               rdMux;
  logic [SEQ_COUNT-1:0]            pvWr;
  logic [SEQ_COUNT-1:0]            limWr;
  logic [SEQ_COUNT-1:0]            offWr;
  logic [SEQ_COUNT-1:0]            wrapPulse;
  logic [SEQ_COUNT-1:0]            status_reg;
  logic [SEQ_COUNT-1:0]            status_next;
  logic [SEQ_COUNT-1:0]            mask_reg;
  logic [SEQ_COUNT-1:0]            mask_next;
  logic [SEQ_COUNT-1:0][STEP_W-1:0] limit_reg;
  logic [DATA_W-1:0]               prdata_reg;
  logic                            pready_reg;
  logic                            pslverr_reg;
  logic                            irq_reg;
  ssb_cmd_t [SEQ_COUNT-1:0]        cmdIn;
  ssb_view_t [SEQ_COUNT-1:0]       chanView;
  // assertion helpers
  ssb_cmd_t [SEQ_COUNT-1:0]        cmdPrev_reg;
  logic [SEQ_COUNT-1:0]            upRise;
  logic [SEQ_COUNT-1:0]            dnRise;
  logic [SEQ_COUNT-1:0]            quiet;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] base,
                                  input int                idx);
    regHit = (addr == (base + ADDR_W'(idx) * WORD_STRIDE));
  endfunction

  assign setup = psel & ~penable;
  assign wrAcc = psel & penable & pwrite & pready_reg;

  // address decode and read mux
  always_comb begin
    statusWr  = wrAcc && (paddr == STATUS_OFS);
    maskWr    = wrAcc && (paddr == MASK_OFS);
    addrKnown = 1'b0;
    rdMux     = DATA_ZERO;
    pvWr      = SEQ_NONE;
    limWr     = SEQ_NONE;
    offWr     = SEQ_NONE;
    unique case (paddr)
      STATUS_OFS: begin
        addrKnown                = 1'b1;
        rdMux[SEQ_COUNT-1:0]     = status_reg;
      end
      MASK_OFS: begin
        addrKnown                = 1'b1;
        rdMux[SEQ_COUNT-1:0]     = mask_reg;
      end
      STATE_OFS: begin
        addrKnown = 1'b1;
        for (int n = 0; n < SEQ_COUNT; n++) begin
          rdMux[STATE_ACT_LSB + n] = chanView[n].active;
          rdMux[STATE_CMP_LSB + n] = chanView[n].complete;
        end
      end
      OFF_OFS: begin
        addrKnown = 1'b1;
      end
      default: begin
      end
    endcase
    for (int n = 0; n < SEQ_COUNT; n++) begin
      offWr[n] = wrAcc && (paddr == OFF_OFS) && pwdata[n];
      // counter n present value is sequencer n step
      if (regHit(paddr, PV_BASE, n)) begin
        addrKnown            = 1'b1;
        pvWr[n]              = wrAcc;
        rdMux[STEP_W-1:0]    = chanView[n].step;
      end
      if (regHit(paddr, LIMIT_BASE, n)) begin
        addrKnown            = 1'b1;
        limWr[n]             = wrAcc;
        rdMux[STEP_W-1:0]    = limit_reg[n];
      end
    end
  end

  // software deactivation joins the ladder one
  always_comb begin
    for (int n = 0; n < SEQ_COUNT; n++) begin
      cmdIn[n]            = seqCmd[n];
      cmdIn[n].deactivate = seqCmd[n].deactivate | offWr[n];
    end
  end

  // apb answer: zero wait, data sampled in setup
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_reg  <= DATA_ZERO;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup) begin
        prdata_reg  <= pwrite ? DATA_ZERO : rdMux;
        pslverr_reg <= ~addrKnown;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int n = 0; n < SEQ_COUNT; n++) begin
        limit_reg[n] <= LIMIT_RST;
      end
    end else begin
      for (int n = 0; n < SEQ_COUNT; n++) begin
        if (limWr[n]) begin
          limit_reg[n] <= pwdata[STEP_W-1:0];
        end
      end
    end
  end

  // wrap events: set wins over write-one clear
  assign status_next = (status_reg & ~(statusWr ? pwdata[SEQ_COUNT-1:0] : SEQ_NONE))
                     | wrapPulse;
  assign mask_next   = maskWr ? pwdata[SEQ_COUNT-1:0] : mask_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_reg <= SEQ_NONE;
      mask_reg   <= SEQ_NONE;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= |(status_next & mask_next);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmdPrev_reg <= '0;
    end else begin
      cmdPrev_reg <= cmdIn;
    end
  end

  always_comb begin
    for (int n = 0; n < SEQ_COUNT; n++) begin
      upRise[n] = (cmdIn[n].advance & ~cmdPrev_reg[n].advance)
                | (cmdIn[n].countUp & ~cmdPrev_reg[n].countUp);
      dnRise[n] = cmdIn[n].countDown & ~cmdPrev_reg[n].countDown;
      quiet[n]  = ~cmdIn[n].deactivate & ~cmdIn[n].jump & ~pvWr[n];
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;

  irq_level_a: assert property (
    irq == |(status_reg & mask_reg)
  ) else $error("interrupt level disagrees with status and mask");

  status_clear_a: assert property (
    statusWr && pwdata[0] && !wrapPulse[0] |=> !status_reg[0]
  ) else $error("status bit not cleared by writing one");

  status_hold_a: assert property (
    !statusWr && (wrapPulse == SEQ_NONE) |=> $stable(status_reg)
  ) else $error("status changed with no event or clear");

  mask_write_a: assert property (
    maskWr |=> mask_reg == $past(pwdata[SEQ_COUNT-1:0])
  ) else $error("mask write did not land");

  mask_hold_a: assert property (
    !maskWr |=> $stable(mask_reg)
  ) else $error("mask changed without a write");

  unmapped_err_a: assert property (
    setup && !addrKnown |=> pslverr && (prdata == DATA_ZERO)
  ) else $error("unmapped access was not refused");

  write_ignored_a: assert property (
    wrAcc && !addrKnown |=> $stable(mask_reg) && $stable(limit_reg)
  ) else $error("unmapped write changed a register");

  read_hold_a: assert property (
    !setup |=> $stable(prdata) && $stable(pslverr)
  ) else $error("read answer changed outside a setup cycle");

  // eight sequencers, each on its own counter
  for (genvar n = 0; n < SEQ_COUNT; n++) begin : g_seq
    ssb_seq_chan u_chan (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .cmd       (cmdIn[n]),
      .swLoad    (pvWr[n]),
      .swValue   (pwdata[STEP_W-1:0]),
      .limit     (limit_reg[n]),
      .view      (chanView[n]),
      .stepFlag  (stepFlag[n]),
      .wrapPulse (wrapPulse[n])
    );

    assign completeFlag[n] = chanView[n].complete;

    first_step_a: assert property (
      quiet[n] && upRise[n] && !chanView[n].active
      |=> chanView[n].active && (chanView[n].step == STEP_ONE)
    ) else $error("first advance did not reach step one");

    inc_one_a: assert property (
      quiet[n] && upRise[n] && chanView[n].active
      && (chanView[n].step != limit_reg[n])
      |=> chanView[n].step == $past(chanView[n].step) + STEP_ONE
    ) else $error("advance did not add exactly one");

    held_level_a: assert property (
      quiet[n] && !upRise[n] && !dnRise[n] |=> $stable(chanView[n])
    ) else $error("sequencer moved without an edge");

    wrap_zero_a: assert property (
      quiet[n] && upRise[n] && chanView[n].active
      && (chanView[n].step == limit_reg[n])
      |=> (chanView[n].step == STEP_ZERO) && chanView[n].complete
      ##1 status_reg[n]
    ) else $error("wrap at limit missing or flag not raised");

    complete_hold_a: assert property (
      chanView[n].complete && !cmdIn[n].deactivate && !upRise[n]
      |=> chanView[n].complete
    ) else $error("completion flag dropped before next increment");

    flag_decode_a: assert property (
      stepFlag[n] == ssb_decode(chanView[n].active, chanView[n].step)
    ) else $error("step flags do not match the step");

    off_clear_a: assert property (
      cmdIn[n].deactivate
      |=> !chanView[n].active && (stepFlag[n] == FLAG_NONE)
    ) else $error("deactivate left the sequencer active");

    jump_load_a: assert property (
      !cmdIn[n].deactivate && cmdIn[n].jump
      |=> chanView[n].active && (chanView[n].step == $past(cmdIn[n].jumpStep))
    ) else $error("jump did not load the step");

    count_down_a: assert property (
      quiet[n] && !upRise[n] && dnRise[n] && chanView[n].active
      && (chanView[n].step != STEP_ZERO)
      |=> chanView[n].step == $past(chanView[n].step) - STEP_ONE
    ) else $error("count down did not step back by one");

    sw_load_a: assert property (
      !cmdIn[n].deactivate && !cmdIn[n].jump && pvWr[n]
      |=> chanView[n].active
      && (chanView[n].step == $past(pwdata[STEP_W-1:0]))
    ) else $error("present value write did not set the step");

    status_set_a: assert property (
      wrapPulse[n] |=> status_reg[n]
    ) else $error("wrap did not set its status bit");

    complete_clear_a: assert property (
      quiet[n] && upRise[n]
      && !(chanView[n].active && (chanView[n].step == limit_reg[n]))
      |=> !chanView[n].complete
    ) else $error("increment left the completion flag set");

    flag_inactive_a: assert property (
      !chanView[n].active |-> stepFlag[n] == FLAG_NONE
    ) else $error("inactive sequencer shows a step flag");

    complete_off_a: assert property (
      cmdIn[n].deactivate |=> !chanView[n].complete
    ) else $error("deactivate left the completion flag set");

    off_write_a: assert property (
      offWr[n] |=> !chanView[n].active
    ) else $error("software deactivate was ignored");

    jump_keep_a: assert property (
      !cmdIn[n].deactivate && cmdIn[n].jump
      |=> chanView[n].complete == $past(chanView[n].complete)
    ) else $error("jump changed the completion flag");

    down_idle_a: assert property (
      quiet[n] && !upRise[n] && dnRise[n] && !chanView[n].active
      |=> $stable(chanView[n])
    ) else $error("count down moved an inactive sequencer");

    down_wrap_a: assert property (
      quiet[n] && !upRise[n] && dnRise[n] && chanView[n].active
      && (chanView[n].step == STEP_ZERO)
      |=> chanView[n].step == $past(limit_reg[n])
    ) else $error("count down below step zero missed the limit");

    limit_write_a: assert property (
      limWr[n] |=> limit_reg[n] == $past(pwdata[STEP_W-1:0])
    ) else $error("limit write did not land");

    limit_hold_a: assert property (
      !limWr[n] |=> $stable(limit_reg[n])
    ) else $error("limit changed without a write");

    pv_read_a: assert property (
      setup && !pwrite && regHit(paddr, PV_BASE, n)
      |=> (prdata[STEP_W-1:0] == $past(chanView[n].step))
      && (prdata[DATA_W-1:STEP_W] == '0)
    ) else $error("present value read is not the step");
  end
endmodule

// ==== verilog/ssb_pkg.sv ====
// ssb_pkg: constants and carriers for the step sequencer bank
// assumes a single scan clock domain and an apb register port
package ssb_pkg;
  localparam int SEQ_COUNT = 8;
  localparam int STEP_W    = 16;
  localparam int FLAG_N    = 32;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] MASK_OFS    = 8'h04;
  localparam logic [ADDR_W-1:0] STATE_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OFS     = 8'h0c;
  localparam logic [ADDR_W-1:0] PV_BASE     = 8'h20;
  localparam logic [ADDR_W-1:0] LIMIT_BASE  = 8'h40;
  localparam logic [ADDR_W-1:0] WORD_STRIDE = 8'h04;

  localparam int STATE_ACT_LSB = 0;
  localparam int STATE_CMP_LSB = 8;

  localparam logic [STEP_W-1:0]    LIMIT_RST = 16'h001f;
  localparam logic [STEP_W-1:0]    STEP_ZERO = 16'h0000;
  localparam logic [STEP_W-1:0]    STEP_ONE  = 16'h0001;
  localparam logic [SEQ_COUNT-1:0] SEQ_NONE  = 8'h00;
  localparam logic [DATA_W-1:0]    DATA_ZERO = 32'h0000_0000;
  localparam logic [FLAG_N-1:0]    FLAG_NONE = 32'h0000_0000;

  typedef struct packed {
    logic              advance;
    logic              countUp;
    logic              countDown;
    logic              deactivate;
    logic              jump;
    logic [STEP_W-1:0] jumpStep;
  } ssb_cmd_t;

  typedef struct packed {
    logic              active;
    logic              complete;
    logic [STEP_W-1:0] step;
  } ssb_view_t;

  typedef enum logic [2:0] {MV_HOLD, MV_OFF, MV_LOAD, MV_UP, MV_DOWN} ssb_move_t;

  function automatic logic [FLAG_N-1:0] ssb_decode(input logic              active,
                                                   input logic [STEP_W-1:0] step);
    ssb_decode = FLAG_NONE;
    if (active && (step < FLAG_N)) begin
      ssb_decode[step[4:0]] = 1'b1;
    end
  endfunction
endpackage

// ==== verilog/ssb_seq_chan.sv ====
// ssb_seq_chan: one sequencer sharing its step with one counter
// assumes commands are levels from logic on clk_sys
`timescale 1ns/1ps
module ssb_seq_chan
  import ssb_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // commands
  input  wire ssb_cmd_t          cmd,
  input  wire logic              swLoad,
  input  wire logic [STEP_W-1:0] swValue,
  input  wire logic [STEP_W-1:0] limit,
  // state
  output ssb_view_t              view,
  output logic [FLAG_N-1:0]      stepFlag,
  output logic                   wrapPulse
);
  logic              advPrev_reg;
  logic              upPrev_reg;
  logic              dnPrev_reg;
  logic              upEdge;
  logic              dnEdge;
  logic              wrap_next;
  logic              wrap_reg;
  logic [FLAG_N-1:0] flag_reg;
  ssb_move_t         move;
  ssb_view_t         view_reg;
  ssb_view_t         view_next;

  // edges only; a held level does nothing more
  assign upEdge = (cmd.advance & ~advPrev_reg) | (cmd.countUp & ~upPrev_reg);
  assign dnEdge = cmd.countDown & ~dnPrev_reg;

  always_comb begin
    if (cmd.deactivate) begin
      move = MV_OFF;
    end else if (cmd.jump || swLoad) begin
      move = MV_LOAD;
    end else if (upEdge) begin
      move = MV_UP;
    end else if (dnEdge) begin
      move = MV_DOWN;
    end else begin
      move = MV_HOLD;
    end
  end

  always_comb begin
    view_next = view_reg;
    wrap_next = 1'b0;
    unique case (move)
      MV_OFF: begin
        view_next = '0;
      end
      MV_LOAD: begin
        view_next.active = 1'b1;
        view_next.step   = cmd.jump ? cmd.jumpStep : swValue;
      end
      MV_UP: begin
        view_next.complete = 1'b0;
        if (!view_reg.active) begin
          view_next.active = 1'b1;
          view_next.step   = STEP_ONE;
        end else if (view_reg.step == limit) begin
          view_next.step     = STEP_ZERO;
          view_next.complete = 1'b1;
          wrap_next          = 1'b1;
        end else begin
          view_next.step = view_reg.step + STEP_ONE;
        end
      end
      MV_DOWN: begin
        if (view_reg.active) begin
          // below step 0 the sequencer comes back at its limit
          view_next.step = (view_reg.step == STEP_ZERO) ? limit
                                                        : view_reg.step - STEP_ONE;
        end
      end
      MV_HOLD: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      advPrev_reg <= 1'b0;
      upPrev_reg  <= 1'b0;
      dnPrev_reg  <= 1'b0;
    end else begin
      advPrev_reg <= cmd.advance;
      upPrev_reg  <= cmd.countUp;
      dnPrev_reg  <= cmd.countDown;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      view_reg <= '0;
      wrap_reg <= 1'b0;
      flag_reg <= FLAG_NONE;
    end else begin
      view_reg <= view_next;
      wrap_reg <= wrap_next;
      flag_reg <= ssb_decode(view_next.active, view_next.step);
    end
  end

  assign view      = view_reg;
  assign stepFlag  = flag_reg;
  assign wrapPulse = wrap_reg;
endmodule

// ==== bench/ssb_step_sequencer_bank_test.sv ====
// ssb_step_sequencer_bank_test: directed bench for the sequencer bank
// assumes a zero-wait apb slave and level ladder commands on clk_sys
`timescale 1ns/1ps
module ssb_step_sequencer_bank_test;
  import ssb_pkg::*;
  logic                            clk_sys;
  logic                            rst_n;
  logic                            psel;
  logic                            penable;
  logic                            pwrite;
  logic [ADDR_W-1:0]               paddr;
  logic [DATA_W-1:0]               pwdata;
  logic [DATA_W-1:0]               prdata;
  logic                            pready;
  logic                            pslverr;
  ssb_cmd_t [SEQ_COUNT-1:0]        seqCmd;
  logic [SEQ_COUNT-1:0][FLAG_N-1:0] stepFlag;
  logic [SEQ_COUNT-1:0]            completeFlag;
  logic                            irq;
  int                              error_cnt;
  int                              n_tests;
  logic [DATA_W-1:0]               rd;
  logic                            rdErr;
  ssb_cmd_t                        cAdv;
  ssb_cmd_t                        cUp;
  ssb_cmd_t                        cDn;

  ssb_step_sequencer_bank ssb_step_sequencer_bank_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seqCmd(seqCmd), .stepFlag(stepFlag), .completeFlag(completeFlag), .irq(irq)
  );

  always #2 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one transfer, then two idle edges so side effects have landed
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd      = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // command high for hold edges, then low long enough to re-arm
  task automatic pulse(input int n, input ssb_cmd_t c, input int hold);
    seqCmd[n] <= c;
    repeat (hold) @(posedge clk_sys);
    seqCmd[n] <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    seqCmd = '0;
    error_cnt = 0;
    n_tests = 0;
    cAdv = '0;
    cAdv.advance = 1'b1;
    cUp = '0;
    cUp.countUp = 1'b1;
    cDn = '0;
    cDn.countDown = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, LIMIT_BASE, '0);
    chk("limit reset", 32'h0000_001f, rd);
    apb(1'b0, STATE_OFS, '0);
    chk("state reset", 32'h0000_0000, rd);
    chk("flags reset", 32'h0000_0000, stepFlag[0]);
    $display("test reset done");

    pulse(0, cAdv, 4);
    chk("held advance", 32'h0000_0002, stepFlag[0]);
    pulse(0, cAdv, 1);
    chk("second advance", 32'h0000_0004, stepFlag[0]);
    $display("test advance done");

    apb(1'b1, LIMIT_BASE, 32'h0000_0003);
    apb(1'b1, MASK_OFS, 32'h0000_0001);
    pulse(0, cAdv, 1);
    chk("at limit", 32'h0000_0008, stepFlag[0]);
    pulse(0, cAdv, 1);
    chk("wrap flag", 32'h0000_0001, stepFlag[0]);
    chk("complete", 32'h0000_0001, {31'h0, completeFlag[0]});
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, STATE_OFS, '0);
    chk("state wrap", 32'h0000_0101, rd);
    apb(1'b0, STATUS_OFS, '0);
    chk("status", 32'h0000_0001, rd);
    apb(1'b1, MASK_OFS, 32'h0000_0000);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, STATUS_OFS, '0);
    chk("status kept", 32'h0000_0001, rd);
    apb(1'b1, STATUS_OFS, 32'h0000_0001);
    apb(1'b0, STATUS_OFS, '0);
    chk("status clear", 32'h0000_0000, rd);
    pulse(0, cUp, 1);
    chk("count up", 32'h0000_0002, stepFlag[0]);
    chk("complete off", 32'h0000_0000, {31'h0, completeFlag[0]});
    pulse(0, cDn, 1);
    chk("count down", 32'h0000_0001, stepFlag[0]);
    pulse(0, cDn, 1);
    chk("down wrap", 32'h0000_0008, stepFlag[0]);
    $display("test wrap done");

    seqCmd[1].jump <= 1'b1;
    seqCmd[1].jumpStep <= 16'h001f;
    @(posedge clk_sys);
    seqCmd[1] <= '0;
    repeat (2) @(posedge clk_sys);
    chk("jump 31", 32'h8000_0000, stepFlag[1]);
    seqCmd[1].jump <= 1'b1;
    seqCmd[1].jumpStep <= 16'h0028;
    @(posedge clk_sys);
    seqCmd[1] <= '0;
    repeat (2) @(posedge clk_sys);
    chk("jump 40", 32'h0000_0000, stepFlag[1]);
    apb(1'b0, PV_BASE + WORD_STRIDE, '0);
    chk("pv 40", 32'h0000_0028, rd);
    pulse(1, cAdv, 1);
    apb(1'b0, PV_BASE + WORD_STRIDE, '0);
    chk("pv 41", 32'h0000_0029, rd);
    seqCmd[1].deactivate <= 1'b1;
    @(posedge clk_sys);
    seqCmd[1] <= '0;
    repeat (2) @(posedge clk_sys);
    apb(1'b0, STATE_OFS, '0);
    chk("deactivated", 32'h0000_0000, rd & 32'h0000_0002);
    $display("test jump done");

    apb(1'b1, PV_BASE + 8'h08, 32'h0000_000a);
    chk("pv write", 32'h0000_0400, stepFlag[2]);
    apb(1'b1, OFF_OFS, 32'h0000_0004);
    chk("sw deactivate", 32'h0000_0000, stepFlag[2]);
    apb(1'b0, STATE_OFS, '0);
    chk("state bits", 32'h0000_0001, rd);
    seqCmd[3] <= '{advance: 1'b1, jump: 1'b1, jumpStep: 16'h0005, default: 1'b0};
    @(posedge clk_sys);
    seqCmd[3] <= '0;
    repeat (2) @(posedge clk_sys);
    chk("jump over advance", 32'h0000_0020, stepFlag[3]);
    seqCmd[4] <= '{deactivate: 1'b1, jump: 1'b1, jumpStep: 16'h0000, default: 1'b0};
    @(posedge clk_sys);
    seqCmd[4] <= '0;
    repeat (2) @(posedge clk_sys);
    chk("deact over jump", 32'h0000_0000, stepFlag[4]);
    chk("other flags", 32'h0000_0000, stepFlag[5]);
    apb(1'b0, 8'h10, '0);
    chk("unmapped err", 32'h0000_0001, {31'h0, rdErr});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test priority done");
    stop_test();
  end
endmodule
